// [cim_ext_dev.sv]
// External interrupt sources and the vector supplier on the data bus.
// Assumes the bench raises requests; the pins are active low.
module cim_ext_dev (
   input  wire logic       io_request_strobe_n_i,  // Acknowledge strobe
   input  wire logic [3:0] req_i,     // NMI, line 0, line 1, line 2
   input  wire logic [7:0] vec_i,     // Byte given at acknowledge
   output logic      [3:0] pin_n_o,   // Request pins
   output logic      [7:0] data_o     // Data bus to the block
);
   timeunit 1ns;
   timeprecision 1ps;
   assign pin_n_o = ~req_i;
   assign data_o  = io_request_strobe_n_i ? ~vec_i : vec_i;
endmodule : cim_ext_dev

// [cim_intc.sv]
// Interrupt acceptance, vectoring and halt, sleep and I/O stop control.
// Assumes a CPU core that reports opcodes and sample points on clk_i,
// and external pins that are asynchronous and are synchronised here.
// Summary of operation
// - Halt opcode stops execution, halt low
// - Halt keeps clock, refresh, DMA, interrupts
// - Reset pin low six cycles restarts
// - Enabled interrupt or NMI ends halt
// - Sleep stops CPU clock, refresh, DMA
// - Sleep forces address high, data off
// - NMI ends sleep with NMI response
// - Individually masked source keeps sleep
// - Enabled source, global on: respond
// - Enabled source, global off: just resume
// - I/O stop bit halts on-chip I/O
// - I/O stop plus sleep: system stop
// - Fixed priority over twelve sources
// - Undefined opcode traps, flag, vector zero
// - NMI edge: clear DMA, save flag, 0066H
// - Line 0 sampled at last cycle point
// - Line 0 mode chosen, reset mode 0
// - Mode 0 takes instruction from bus
// - Mode 1 pushes PC, vectors 0038H
// - Mode 2 bus vector byte, table fetch
// - Other sources use programmable low-byte bits 7:5
// - Internal sources masked global and locally
// - NMI return restores global flag
//
// The address map and the Wishbone register port were left to the implementer.
module cim_intc
   import cim_pkg::*;
(
   input  wire logic        clk_i,                // System clock
   input  wire logic        rst_i,                // Synchronous reset
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Pins, asynchronous, active low except the data bus
   input  wire logic        nmi_n_i,
   input  wire logic        line0_n_i,
   input  wire logic        line1_n_i,
   input  wire logic        line2_n_i,
   input  wire logic        cpu_reset_n_i,
   input  wire logic [7:0]  data_bus_i,
   // Core events, same clock
   input  wire logic        opcode_valid_i,       // Opcode fetched this cycle
   input  wire logic [7:0]  opcode_i,
   input  wire logic        prefix_ed_i,          // Opcode is second byte after ED
   input  wire logic        undef_opcode_i,       // Undefined opcode fetched
   input  wire logic        sample_pt_i,          // Line 0 sample point
   input  wire logic        enable_ints_i,
   input  wire logic        mask_all_i,
   input  wire logic        return_from_nmi_i,
   input  wire logic        mode_load_i,          // Set response mode
   input  wire logic [1:0]  mode_sel_i,
   // Internal peripheral requests and their local enables
   input  wire logic [6:0]  periph_req_i,
   input  wire logic [6:0]  periph_en_i,
   // Response to the core
   output logic             resp_valid_o,         // One cycle pulse
   output logic [3:0]       resp_src_o,
   output logic [15:0]      resp_addr_o,          // Restart or table entry address
   output logic             resp_push_pc_o,
   output logic             resp_table_o,         // Address is a vector table entry
   output logic             resp_instr_valid_o,   // Mode 0 instruction taken
   output logic [7:0]       resp_instr_o,
   output logic             sleep_exit_o,         // Resume without response
   output logic             cpu_reset_o,          // Reset sequence active
   // Power and bus control
   output logic             halt_n_o,
   output logic             dummy_fetch_o,
   output logic             cpu_clk_en_o,
   output logic             refresh_en_o,
   output logic             dma_en_o,
   output logic             io_run_o,
   output logic             sys_stop_o,
   output logic             addr_force_high_o,
   output logic             data_oe_o,
   output logic             fetch_cycle_n_o,
   output logic             io_request_strobe_n_o
);

   // Whole module state
   typedef struct packed {
      logic [12:0] pin_s1;      // First synchroniser stage
      logic [12:0] pin_s2;      // Second synchroniser stage
      logic        nmi_d;       // Delayed NMI level for edge detect
      logic        nmi_pend;    // NMI edge waiting for response
      cim_mode_t   mode;
      cim_ack_t    ack;
      logic [2:0]  ack_cnt;
      logic        ack_mode0;   // Ack cycle belongs to mode 0
      logic        global_ie;
      logic        saved_ie;
      logic [1:0]  int_mode;
      logic [7:0]  vec_high;
      logic [2:0]  vec_low;
      logic        trap_flag;
      logic [2:0]  line_en;
      logic        io_stop;
      logic        dma_master;
      logic [2:0]  rst_cnt;
      logic        rst_act;
      logic        resp_valid;
      logic [3:0]  resp_src;
      logic [15:0] resp_addr;
      logic        resp_push;
      logic        resp_table;
      logic        resp_ivld;
      logic [7:0]  resp_instr;
      logic        sleep_exit;
      logic        wb_ack;
      logic [7:0]  wb_dat;
   } cim_state_t;

   cim_state_t st_r;            // Registered state
   cim_state_t st_nxt;          // Next state

   logic       nmi_edge;        // Falling NMI edge seen
   logic       line0_act;       // Line 0 acceptable now
   logic [8:0] vreq;            // Vectored requests, highest first at bit 0
   logic       smp_ok;          // Sampling allowed this cycle
   logic       wb_req;          // New bus request
   logic [5:0] wb_idx;          // Register index
   logic [3:0] vidx;            // Winning vectored source

   // Pin decode from synchronised levels
   assign nmi_edge  = st_r.nmi_d && !st_r.pin_s2[0];
   // Line 0 masked by both flags
   assign line0_act = st_r.global_ie && st_r.line_en[0] && !st_r.pin_s2[1];
   // Internal masked locally and stopped I/O
   assign vreq = {periph_req_i & periph_en_i & {7{!st_r.io_stop}},
                  !st_r.pin_s2[3] && st_r.line_en[2],
                  !st_r.pin_s2[2] && st_r.line_en[1]};
   // Halt and sleep sample at any cycle
   assign smp_ok = (st_r.mode != MD_RUN) || sample_pt_i;
   assign wb_req = wb_cyc_i && wb_stb_i && !st_r.wb_ack;
   assign wb_idx = wb_adr_i[7:2];

   // Next state
   always_comb begin
      st_nxt = st_r;
      vidx = 4'h0;
      for (int i = 8; i >= 0; i--) begin
         if (vreq[i]) begin
            vidx = 4'(i);
         end
      end
      // Synchronisers and edge history
      st_nxt.pin_s1 = {data_bus_i, cpu_reset_n_i, line2_n_i, line1_n_i, line0_n_i, nmi_n_i};
      st_nxt.pin_s2 = st_r.pin_s1;
      st_nxt.nmi_d  = st_r.pin_s2[0];
      // Pulses default low
      st_nxt.resp_valid = 1'b0;
      st_nxt.resp_ivld  = 1'b0;
      st_nxt.sleep_exit = 1'b0;
      st_nxt.wb_ack     = wb_req;
      if (st_r.pin_s2[4]) begin
         st_nxt.rst_cnt = 3'h0;
      end else if (st_r.rst_cnt != RST_HOLD_CYC) begin
         st_nxt.rst_cnt = st_r.rst_cnt + 3'h1;
      end
      st_nxt.rst_act = !st_r.pin_s2[4] && (st_nxt.rst_cnt == RST_HOLD_CYC);
      // Register reads
      if (wb_req) begin
         case (wb_idx)
            IDX_VEC_HIGH: st_nxt.wb_dat = st_r.vec_high;
            IDX_STATUS:   st_nxt.wb_dat = {2'h0, st_r.int_mode, st_r.saved_ie,
                                           st_r.global_ie, st_r.mode};
            IDX_DMA_WAIT: st_nxt.wb_dat = {7'h00, st_r.dma_master};
            IDX_VEC_LOW:  st_nxt.wb_dat = {st_r.vec_low, 5'h00};
            IDX_TRAP_CTL: st_nxt.wb_dat = {st_r.trap_flag, 4'h0, st_r.line_en};
            IDX_IO_CTL:   st_nxt.wb_dat = {2'h0, st_r.io_stop, 5'h00};
            default:      st_nxt.wb_dat = 8'h00;
         endcase
      end
      // Register writes, low byte lane only
      if (wb_req && wb_we_i && wb_sel_i[0]) begin
         case (wb_idx)
            IDX_VEC_HIGH: st_nxt.vec_high = wb_dat_i[7:0];
            IDX_DMA_WAIT: st_nxt.dma_master = wb_dat_i[DMA_MASTER_BIT];
            IDX_VEC_LOW:  st_nxt.vec_low = wb_dat_i[7:VEC_LOW_LSB];
            IDX_TRAP_CTL: begin
               // Writing zero clears the trap flag
               if (!wb_dat_i[TRAP_FLAG_BIT]) begin
                  st_nxt.trap_flag = 1'b0;
               end
               st_nxt.line_en = wb_dat_i[2:0];
            end
            IDX_IO_CTL:   st_nxt.io_stop = wb_dat_i[IO_STOP_BIT];
            default:      st_nxt.io_stop = st_nxt.io_stop;
         endcase
      end
      // Flag instructions from the core
      if (enable_ints_i) begin
         st_nxt.global_ie = 1'b1;
         st_nxt.saved_ie  = 1'b1;
      end else if (mask_all_i) begin
         st_nxt.global_ie = 1'b0;
         st_nxt.saved_ie  = 1'b0;
      end else if (return_from_nmi_i) begin
         st_nxt.global_ie = st_r.saved_ie;
      end
      if (mode_load_i) begin
         st_nxt.int_mode = mode_sel_i;
      end
      // Vector acknowledge cycle
      case (st_r.ack)
         AK_BUS: begin
            if (st_r.ack_cnt == ACK_CYC - 3'h1) begin
               st_nxt.ack = AK_DONE;
            end else begin
               st_nxt.ack_cnt = st_r.ack_cnt + 3'h1;
            end
         end
         AK_DONE: begin
            st_nxt.ack        = AK_IDLE;
            st_nxt.resp_valid = 1'b1;
            st_nxt.resp_src   = SRC_LINE0;
            if (st_r.ack_mode0) begin
               st_nxt.resp_ivld  = 1'b1;
               st_nxt.resp_instr = st_r.pin_s2[12:5];
               st_nxt.resp_addr  = 16'h0000;
               st_nxt.resp_push  = 1'b0;
               st_nxt.resp_table = 1'b0;
            end else begin
               st_nxt.resp_addr  = {st_r.vec_high, st_r.pin_s2[12:5]};
               st_nxt.resp_push  = 1'b1;
               st_nxt.resp_table = 1'b1;
            end
         end
         default: begin
            if (st_r.rst_act) begin
               st_nxt.mode = MD_RUN;
            end else if (undef_opcode_i && st_r.mode == MD_RUN) begin
               st_nxt.trap_flag  = 1'b1;
               st_nxt.resp_valid = 1'b1;
               st_nxt.resp_src   = SRC_TRAP;
               st_nxt.resp_addr  = TRAP_VEC;
               st_nxt.resp_push  = 1'b1;
               st_nxt.resp_table = 1'b0;
            end else if (st_r.nmi_pend) begin
               st_nxt.nmi_pend   = 1'b0;
               st_nxt.dma_master = 1'b0;
               st_nxt.saved_ie   = st_r.global_ie;
               st_nxt.global_ie  = 1'b0;
               st_nxt.mode       = MD_RUN;
               st_nxt.resp_valid = 1'b1;
               st_nxt.resp_src   = SRC_NMI;
               st_nxt.resp_addr  = NMI_VEC;
               st_nxt.resp_push  = 1'b1;
               st_nxt.resp_table = 1'b0;
            end else if (line0_act && smp_ok) begin
               // Line 0 accepted at sample point
               st_nxt.global_ie = 1'b0;
               st_nxt.saved_ie  = 1'b0;
               st_nxt.mode      = MD_RUN;
               if (st_r.int_mode == 2'h1) begin
                  st_nxt.resp_valid = 1'b1;
                  st_nxt.resp_src   = SRC_LINE0;
                  st_nxt.resp_addr  = MODE1_VEC;
                  st_nxt.resp_push  = 1'b1;
                  st_nxt.resp_table = 1'b0;
               end else begin
                  // Modes 0 and 2 run a bus acknowledge
                  st_nxt.ack       = AK_BUS;
                  st_nxt.ack_cnt   = 3'h0;
                  st_nxt.ack_mode0 = (st_r.int_mode == 2'h0);
               end
            end else if (st_r.global_ie && (|vreq) && smp_ok) begin
               // Enabled source ends sleep with response
               st_nxt.global_ie  = 1'b0;
               st_nxt.saved_ie   = 1'b0;
               st_nxt.mode       = MD_RUN;
               st_nxt.resp_valid = 1'b1;
               st_nxt.resp_src   = vidx;
               st_nxt.resp_addr  = {st_r.vec_high, st_r.vec_low, vidx, 1'b0};
               st_nxt.resp_push  = 1'b1;
               st_nxt.resp_table = 1'b1;
            end else if (st_r.mode == MD_SLEEP &&
                         ((st_r.line_en[0] && !st_r.pin_s2[1]) || (|vreq))) begin
               // Only globally masked sources reach here; individually masked ones keep sleep
               st_nxt.mode       = MD_RUN;
               st_nxt.sleep_exit = 1'b1;
            end else if (st_r.mode == MD_RUN && opcode_valid_i && opcode_i == OPC_HALT) begin
               // With I/O stop, the sleep form after ED is system stop
               st_nxt.mode = prefix_ed_i ? MD_SLEEP : MD_HALT;
            end
         end
      endcase
      // NMI edge set wins over its clear
      if (nmi_edge) begin
         st_nxt.nmi_pend = 1'b1;
      end
      if (st_r.rst_act) begin
         st_nxt.ack        = AK_IDLE;
         st_nxt.global_ie  = 1'b0;
         st_nxt.saved_ie   = 1'b0;
         st_nxt.int_mode   = INT_MODE_RST;
         st_nxt.trap_flag  = 1'b0;
         st_nxt.line_en    = LINE_EN_RST;
         st_nxt.io_stop    = 1'b0;
         st_nxt.dma_master = 1'b0;
         st_nxt.nmi_pend   = 1'b0;
         st_nxt.resp_valid = 1'b0;
      end
      // Restart at address zero on release
      if (st_r.rst_act && !st_nxt.rst_act) begin
         st_nxt.resp_valid = 1'b1;
         st_nxt.resp_src   = SRC_RESET;
         st_nxt.resp_addr  = RESET_VEC;
         st_nxt.resp_push  = 1'b0;
         st_nxt.resp_table = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r          <= '0;
         st_r.pin_s1   <= 13'h1FFF;
         st_r.pin_s2   <= 13'h1FFF;
         st_r.nmi_d    <= 1'b1;
         st_r.mode     <= MD_RUN;
         st_r.ack      <= AK_IDLE;
         st_r.int_mode <= INT_MODE_RST;
         st_r.vec_high <= VEC_HIGH_RST;
         st_r.vec_low  <= VEC_LOW_RST;
         st_r.line_en  <= LINE_EN_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs from state
   assign wb_dat_o              = {24'h000000, st_r.wb_dat};
   assign wb_ack_o              = st_r.wb_ack;
   assign resp_valid_o          = st_r.resp_valid;
   assign resp_src_o            = st_r.resp_src;
   assign resp_addr_o           = st_r.resp_addr;
   assign resp_push_pc_o        = st_r.resp_push;
   assign resp_table_o          = st_r.resp_table;
   assign resp_instr_valid_o    = st_r.resp_ivld;
   assign resp_instr_o          = st_r.resp_instr;
   assign sleep_exit_o          = st_r.sleep_exit;
   assign cpu_reset_o           = st_r.rst_act;
   assign halt_n_o              = (st_r.mode != MD_HALT);
   assign dummy_fetch_o         = (st_r.mode == MD_HALT);
   // Halt keeps clock, refresh and DMA
   assign cpu_clk_en_o          = (st_r.mode != MD_SLEEP);
   assign refresh_en_o          = (st_r.mode != MD_SLEEP);
   assign dma_en_o              = st_r.dma_master && (st_r.mode != MD_SLEEP);
   assign io_run_o              = !st_r.io_stop;
   assign sys_stop_o            = st_r.io_stop && (st_r.mode == MD_SLEEP);
   assign addr_force_high_o     = (st_r.mode == MD_SLEEP);
   assign data_oe_o             = 1'b0;
   assign fetch_cycle_n_o       = (st_r.ack != AK_BUS);
   assign io_request_strobe_n_o = (st_r.ack != AK_BUS);

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_ack_start;
      $rose(st_r.ack == AK_BUS);
   endsequence
   sequence s_ack_body;
      (!fetch_cycle_n_o && !io_request_strobe_n_o)[*5];
   endsequence
   sequence s_rst_low;
      !st_r.pin_s2[4] [*6];
   endsequence

   a_halt_entry: assert property (
      (st_r.mode == MD_RUN && st_r.ack == AK_IDLE && !st_r.rst_act && opcode_valid_i &&
       opcode_i == OPC_HALT && !prefix_ed_i && !undef_opcode_i && !st_r.nmi_pend &&
       !(line0_act && smp_ok) && !(st_r.global_ie && |vreq && smp_ok))
      |=> !halt_n_o && dummy_fetch_o && cpu_clk_en_o)
      else $error("halt not entered");
   a_sleep_stops: assert property (
      st_r.mode == MD_SLEEP |-> !cpu_clk_en_o && !refresh_en_o && !dma_en_o)
      else $error("sleep left clocks running");
   a_sleep_bus: assert property (
      st_r.mode == MD_SLEEP |-> addr_force_high_o && !data_oe_o && io_request_strobe_n_o)
      else $error("sleep bus levels wrong");
   a_reset_hold: assert property (
      s_rst_low |=> cpu_reset_o)
      else $error("reset hold not honoured");
   a_nmi_vector: assert property (
      (st_r.nmi_pend && st_r.ack == AK_IDLE && !st_r.rst_act && !undef_opcode_i)
      |=> resp_valid_o && resp_addr_o == NMI_VEC && resp_push_pc_o && !st_r.global_ie &&
          !st_r.dma_master && st_r.saved_ie == $past(st_r.global_ie))
      else $error("NMI response wrong");
   a_trap_flag: assert property (
      (undef_opcode_i && st_r.mode == MD_RUN && st_r.ack == AK_IDLE && !st_r.rst_act)
      |=> st_r.trap_flag && resp_valid_o && resp_addr_o == TRAP_VEC && resp_src_o == SRC_TRAP)
      else $error("trap not taken");
   a_sleep_masked: assert property (
      (st_r.mode == MD_SLEEP && !st_r.nmi_pend && !st_r.rst_act && !nmi_edge &&
       !(st_r.line_en[0] && !st_r.pin_s2[1]) && vreq == 9'h000)
      |=> st_r.mode == MD_SLEEP && !resp_valid_o)
      else $error("masked source woke sleep");
   a_sleep_resume: assert property (
      (st_r.mode == MD_SLEEP && !st_r.global_ie && !st_r.nmi_pend && !st_r.rst_act &&
       st_r.ack == AK_IDLE && |vreq)
      |=> st_r.mode == MD_RUN && sleep_exit_o && !resp_valid_o)
      else $error("sleep resume wrong");
   a_mode1_vector: assert property (
      (st_r.ack == AK_IDLE && !st_r.rst_act && !st_r.nmi_pend && !undef_opcode_i &&
       line0_act && smp_ok && st_r.int_mode == 2'h1)
      |=> resp_valid_o && resp_addr_o == MODE1_VEC && resp_push_pc_o && !st_r.saved_ie)
      else $error("mode 1 response wrong");
   a_mode2_ack: assert property (disable iff (rst_i || st_r.rst_act)
      s_ack_start |-> s_ack_body ##2 (resp_valid_o && resp_src_o == SRC_LINE0))
      else $error("vector acknowledge timing wrong");
   a_vector_low: assert property (
      (resp_valid_o && resp_table_o && resp_src_o < SRC_NMI)
      |-> resp_addr_o[7:5] == $past(st_r.vec_low) && resp_addr_o[4:0] == {resp_src_o, 1'b0})
      else $error("vector low byte wrong");
   a_return_from_nmi_restore: assert property (
      (return_from_nmi_i && !enable_ints_i && !mask_all_i && st_r.ack == AK_IDLE &&
       !st_r.rst_act && !undef_opcode_i && !st_r.nmi_pend && !(line0_act && smp_ok) &&
       !(st_r.global_ie && |vreq && smp_ok))
      |=> st_r.global_ie == $past(st_r.saved_ie))
      else $error("NMI return did not restore flag");

endmodule : cim_intc

// [cim_pkg.sv]
// Constants and types for the interrupt and power mode controller.
// Assumes one 40 MHz system clock and a classic Wishbone register port.
package cim_pkg;

   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_VEC_HIGH   = 6'h30;  // Table page byte
   localparam logic [5:0] IDX_STATUS     = 6'h31;  // Mode and flag status, read only
   localparam logic [5:0] IDX_DMA_WAIT   = 6'h32;  // DMA master enable
   localparam logic [5:0] IDX_VEC_LOW    = 6'h33;  // Programmable vector low bits
   localparam logic [5:0] IDX_TRAP_CTL   = 6'h34;  // Trap flag and line enables
   localparam logic [5:0] IDX_IO_CTL     = 6'h3F;  // I/O stop control

   // Field positions
   localparam int TRAP_FLAG_BIT  = 7;              // Trap flag in trap control
   localparam int IO_STOP_BIT    = 5;              // I/O stop in I/O control
   localparam int DMA_MASTER_BIT = 0;              // DMA master enable
   localparam int VEC_LOW_LSB    = 5;              // Low edge of programmable bits

   // Reset values
   localparam logic [2:0] LINE_EN_RST  = 3'h1;     // Line 0 enabled, lines 1 and 2 off
   localparam logic [1:0] INT_MODE_RST = 2'h0;     // Response mode 0
   localparam logic [7:0] VEC_HIGH_RST = 8'h00;
   localparam logic [2:0] VEC_LOW_RST  = 3'h0;

   // Opcodes and restart addresses
   localparam logic [7:0]  OPC_HALT    = 8'h76;    // Halt, also sleep second byte
   localparam logic [15:0] NMI_VEC     = 16'h0066;
   localparam logic [15:0] MODE1_VEC   = 16'h0038;
   localparam logic [15:0] TRAP_VEC    = 16'h0000;
   localparam logic [15:0] RESET_VEC   = 16'h0000;

   // Timing counts in system clocks
   localparam logic [2:0] RST_HOLD_CYC = 3'h6;     // Reset pin low time
   localparam logic [2:0] ACK_WAITS    = 3'h2;     // Wait states on vector fetch
   localparam logic [2:0] ACK_CYC      = 3'h3 + ACK_WAITS;  // T1 T2 Tw Tw T3

   // Response source codes
   localparam logic [3:0] SRC_NMI   = 4'h9;
   localparam logic [3:0] SRC_LINE0 = 4'hA;
   localparam logic [3:0] SRC_TRAP  = 4'hB;
   localparam logic [3:0] SRC_RESET = 4'hC;

   // Operating mode, Gray along run, halt, sleep
   typedef enum logic [1:0] {
      MD_RUN   = 2'b00,
      MD_HALT  = 2'b01,
      MD_SLEEP = 2'b11
   } cim_mode_t;

   // Vector acknowledge cycle
   typedef enum logic [1:0] {
      AK_IDLE = 2'b00,
      AK_BUS  = 2'b01,
      AK_DONE = 2'b11
   } cim_ack_t;

endpackage : cim_pkg

// [tb.sv]
// Self-checking bench for the interrupt and power mode controller.
// Assumes the external source model in cim_ext_dev.sv.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cim_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, opv = 0, pfx = 0, rn = 1;
   logic [7:0] adr = 0, vec = 0, q, dbus, ins;
   logic [31:0] wd = 0, rd;
   logic [4:0] ev = 0;  // Undefined, enable, mask, nmi return, mode load
   logic [1:0] ms = 0;
   logic sp = 1;  // Line 0 sample point
   logic [6:0] prq = 0, pen = 0;  // Peripheral requests and enables
   logic [3:0] req = 0, pin_n, src;
   logic [15:0] ra;
   logic ack, rv, sx, crst, hn, cke, afh, io_request_strobe_n, iorun, sstop, pp, iv;
   int n_errors = 0, checked = 0, cyc_n = 0;
   always #12.5 clk_i = ~clk_i;
   cim_ext_dev u_cim_ext_dev (.io_request_strobe_n_i(io_request_strobe_n), .req_i(req), .vec_i(vec), .pin_n_o(pin_n),
      .data_o(dbus));
   cim_intc u_cim_intc (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
      .nmi_n_i(pin_n[0]), .line0_n_i(pin_n[1]), .line1_n_i(pin_n[2]), .line2_n_i(pin_n[3]),
      .cpu_reset_n_i(rn), .data_bus_i(dbus), .opcode_valid_i(opv), .opcode_i(OPC_HALT),
      .prefix_ed_i(pfx), .undef_opcode_i(ev[4]), .sample_pt_i(sp), .enable_ints_i(ev[3]),
      .mask_all_i(ev[2]), .return_from_nmi_i(ev[1]), .mode_load_i(ev[0]), .mode_sel_i(ms),
      .periph_req_i(prq), .periph_en_i(pen), .resp_valid_o(rv), .resp_src_o(src),
      .resp_addr_o(ra), .resp_push_pc_o(pp), .resp_table_o(), .resp_instr_valid_o(iv),
      .resp_instr_o(ins), .sleep_exit_o(sx), .cpu_reset_o(crst), .halt_n_o(hn),
      .dummy_fetch_o(), .cpu_clk_en_o(cke), .refresh_en_o(), .dma_en_o(), .io_run_o(iorun),
      .sys_stop_o(sstop), .addr_force_high_o(afh), .data_oe_o(), .fetch_cycle_n_o(),
      .io_request_strobe_n_o(io_request_strobe_n));
   task automatic give_verdict;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [23:0] g, e);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("Error %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, d);
      cyc <= 1; we <= w; adr <= a; wd <= {24'h0, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rd[7:0];
      cyc <= 0;
      @(posedge clk_i);
   endtask : wb
   task automatic rc(input logic [7:0] a, input logic [23:0] e);
      wb(0, a, 8'h00);
      chk({16'h0, q}, e);
   endtask : rc
   task automatic pl(input logic [4:0] b);
      ev <= b;
      @(posedge clk_i);
      ev <= 0;
      @(posedge clk_i);
   endtask : pl
   task automatic opc(input logic p);
      opv <= 1; pfx <= p;
      @(posedge clk_i);
      opv <= 0;
      repeat (2) @(posedge clk_i);
   endtask : opc
   task automatic wt(input logic s);
      repeat (60) if ((s ? sx : rv) !== 1'b1) @(posedge clk_i);
   endtask : wt
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 3000) begin
         n_errors++;
         give_verdict;
      end
   end
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      rc(8'hC4, 24'h0);
      rc(8'hD0, 24'h1);
      rc(8'h00, 24'h0);
      wb(1, 8'hC8, 8'h01); pl(5'h08); req <= 4'h1;
      wt(0); chk({rv, src, ra}, {1'b1, SRC_NMI, NMI_VEC});
      req <= 0;
      rc(8'hC8, 24'h0);
      rc(8'hC4, 24'h8);
      pl(5'h02); rc(8'hC4, 24'hC);
      ms <= 2'h1; sp <= 0; pl(5'h01); req <= 4'h2; repeat (4) @(posedge clk_i);
      rc(8'hC4, 24'h1C); sp <= 1;
      wt(0); chk({rv, src, ra}, {1'b1, SRC_LINE0, MODE1_VEC});
      req <= 0;
      rc(8'hC4, 24'h10);
      ms <= 2'h2; pl(5'h01); pl(5'h08); wb(1, 8'hC0, 8'h12); vec <= 8'h34; req <= 4'h2;
      wt(0); chk({rv, src, ra}, {1'b1, SRC_LINE0, 16'h1234});
      req <= 0;
      wb(1, 8'hD0, 8'h03); wb(1, 8'hCC, 8'hA0); opc(0);
      chk(hn, 0);
      req <= 4'h4; repeat (8) @(posedge clk_i);
      chk(hn, 0);
      pl(5'h08);
      wt(0); chk({rv, src, ra}, {1'b1, 4'h0, 16'h12A0});
      req <= 0; repeat (3) @(posedge clk_i); opc(1);
      chk({cke, afh}, 2'b01);
      req <= 4'h8; repeat (8) @(posedge clk_i);
      rc(8'hC4, 24'h23);
      req <= 4'h4;
      wt(1); chk(sx, 1);
      req <= 0; pl(5'h10);
      wt(0); chk({rv, src, ra}, {1'b1, SRC_TRAP, TRAP_VEC});
      rc(8'hD0, 24'h83);
      wb(1, 8'hFC, 8'h20);
      chk(iorun, 0);
      opc(1);
      chk(sstop, 1);
      pen <= 7'h01; prq <= 7'h01; repeat (8) @(posedge clk_i);
      chk(sstop, 1); prq <= 0;
      rn <= 0; repeat (12) @(posedge clk_i);
      chk(crst, 1);
      rn <= 1;
      wt(0); chk({rv, src, ra}, {1'b1, SRC_RESET, RESET_VEC});
      rc(8'hC4, 24'h0);
      pl(5'h08); vec <= 8'hC7; req <= 4'h2;
      wt(0); chk({rv, src, iv, pp, ins}, {1'b1, SRC_LINE0, 2'b10, 8'hC7});
      req <= 0; prq <= 7'h01; pen <= 7'h01; repeat (4) @(posedge clk_i);
      pl(5'h08); wt(0); chk({rv, src, ra}, {1'b1, 4'h2, 16'h12A4});
      give_verdict;
   end
endmodule : tb
